// file: mds_top.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mds_top
  import mds_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Host processor status
  output logic             busy,
  output logic             op_done,
  output logic      [3:0]  cc_out
);

  mds_state_t  s_q;
  mds_state_t  s_d;
  mds_alu_if   alu_if ();
  logic        acc;
  logic        start;
  logic        qbit;
  logic        sgn;
  logic        negq;
  logic        qerr;
  logic [31:0] neg32;
  logic [15:0] quo;
  logic [15:0] rem;
  logic [3:0]  cc;

  mds_alu u_alu (
    .bus (alu_if)
  );

  // Partial remainder stays within one divisor, so bit 15 is its true sign
  assign qbit = ~alu_if.sum[15];
  // Booth partial sums can reach 17 bits; overflow restores the true sign
  assign sgn  = alu_if.sum[15] ^ alu_if.ovf;

  function automatic logic [15:0] wmerge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  st);
    wmerge = {st[1] ? d[15:8] : o[15:8], st[0] ? d[7:0] : o[7:0]};
  endfunction

  always_comb
  begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.op_done = 1'b0;
    alu_if.a = s_q.br;
    alu_if.b = s_q.b;
    alu_if.sub = 1'b0;
    alu_if.pass = 1'b0;
    alu_if.cin = 1'b0;
    acc = psel && penable && s_q.pready;
    start = acc && pwrite && !s_q.pslverr && (paddr == ADDR_CTRL) && pstrb[0]
            && pwdata[CTRL_START_BIT] && !s_q.busy;
    neg32 = 32'h0000_0000 - {s_q.br, s_q.dr};
    negq = s_q.negd ^ s_q.b[15];
    rem = s_q.negd ? 16'h0000 - s_q.br : s_q.br;
    quo = negq ? 16'h0000 - s_q.dr : s_q.dr;
    qerr = negq ? (quo == MOST_NEG) : quo[15];
    cc = 4'h0;

    // Read data is captured in the setup cycle; one wait-free access follows
    if (psel && !penable && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      case (paddr)
        ADDR_CTRL:  s_d.prdata = {23'h000000, s_q.busy, 5'h00, s_q.op, 1'b0};
        ADDR_SRC:   s_d.prdata = {16'h0000, s_q.src};
        ADDR_SRCLO: s_d.prdata = {16'h0000, s_q.srclo};
        ADDR_DST:   s_d.prdata = {16'h0000, s_q.dst};
        ADDR_RESHI: s_d.prdata = {16'h0000, s_q.reshi};
        ADDR_RESLO: s_d.prdata = {16'h0000, s_q.reslo};
        ADDR_STAT:  s_d.prdata = {27'h0000000, s_q.done, s_q.cc_out};
        default:
        begin
          s_d.prdata = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // Operand writes are allowed while busy: the sequencer works on copies
    if (acc && pwrite && !s_q.pslverr)
    begin
      case (paddr)
        ADDR_SRC:   s_d.src = wmerge(s_q.src, pwdata, pstrb);
        ADDR_SRCLO: s_d.srclo = wmerge(s_q.srclo, pwdata, pstrb);
        ADDR_DST:   s_d.dst = wmerge(s_q.dst, pwdata, pstrb);
        default:    s_d.dst = s_q.dst;
      endcase
    end

    if (start)
    begin
      s_d.op = mds_op_t'(pwdata[CTRL_OP_LSB+1:CTRL_OP_LSB]);
      s_d.busy = 1'b1;
      s_d.done = 1'b0;
      s_d.st = ST_LOAD;
      s_d.ext = 1'b0;
      s_d.v = 1'b0;
      s_d.c = 1'b0;
      s_d.negd = s_q.src[15];
      s_d.left = !s_q.dst[5];
      s_d.br = s_q.src;
      s_d.b = s_q.src;
      s_d.dr = s_q.srclo;
      s_d.cnt = s_q.dst[5] ? 6'h00 - s_q.dst[5:0] : s_q.dst[5:0];
      case (mds_op_t'(pwdata[CTRL_OP_LSB+1:CTRL_OP_LSB]))
        OP_MUL:
        begin
          s_d.dr = s_q.src;
          s_d.b = s_q.dst;
          s_d.br = 16'h0000;
          s_d.cnt = MUL_STEPS;
        end
        OP_DIV:
        begin
          s_d.b = s_q.dst;
          s_d.cnt = DIV_STEPS;
        end
        OP_ASH:     s_d.dr = 16'h0000;
        default:    s_d.dr = s_q.srclo;
      endcase
    end

    case (s_q.st)
      ST_LOAD:
      begin
        case (s_q.op)
          OP_MUL:
          begin
            s_d.st = ST_MSTEP;
            if (s_q.dr == MOST_NEG)
            begin
              s_d.dr = s_q.b;
              s_d.b = s_q.dr;
              if (s_q.b == MOST_NEG)
              begin
                s_d.br = MUL_SPECIAL_HI;
                s_d.dr = 16'h0000;
                s_d.st = ST_FIN;
              end
            end
          end
          OP_DIV:
          begin
            s_d.st = ST_DFIRST;
            if (s_q.b == 16'h0000)
            begin
              s_d.v = 1'b1;
              s_d.c = 1'b1;
              s_d.st = ST_FIN;
            end
            else if (s_q.negd)
            begin
              s_d.br = neg32[31:16];
              s_d.dr = neg32[15:0];
              if (neg32 == {MOST_NEG, 16'h0000})
              begin
                s_d.v = 1'b1;
                s_d.st = ST_FIN;
              end
            end
          end
          default:
            s_d.st = (s_q.cnt == 6'h00) ? ST_FIN : ST_SSTEP;
        endcase
      end

      ST_MSTEP:
      begin
        alu_if.a = s_q.br;
        alu_if.sub = s_q.dr[0] && !s_q.ext;
        alu_if.pass = (s_q.dr[0] == s_q.ext);
        alu_if.cin = s_q.dr[0] && !s_q.ext;
        s_d.br = {sgn, alu_if.sum[15:1]};
        s_d.dr = {alu_if.sum[0], s_q.dr[15:1]};
        s_d.ext = s_q.dr[0];
        s_d.cnt = s_q.cnt - 6'h01;
        if (s_q.cnt == 6'h01)
          s_d.st = ST_FIN;
      end

      ST_DFIRST:
      begin
        alu_if.a = {s_q.br[14:0], s_q.dr[15]};
        alu_if.sub = !s_q.b[15];
        alu_if.cin = !s_q.b[15];
        s_d.br = alu_if.sum;
        s_d.dr = {s_q.dr[14:0], qbit};
        s_d.st = ST_DSTEP;
        // A set first quotient bit or a lost high bit means over 16 bits
        if (qbit || s_q.br[15])
        begin
          s_d.v = 1'b1;
          s_d.st = ST_FIN;
        end
      end

      ST_DSTEP:
      begin
        alu_if.a = {s_q.br[14:0], s_q.dr[15]};
        alu_if.sub = s_q.dr[0] ^ s_q.b[15];
        alu_if.cin = s_q.dr[0] ^ s_q.b[15];
        s_d.br = alu_if.sum;
        s_d.dr = {s_q.dr[14:0], qbit};
        s_d.cnt = s_q.cnt - 6'h01;
        if (s_q.cnt == 6'h01)
          s_d.st = ST_DFIX;
      end

      ST_DFIX:
      begin
        // A clear last quotient bit leaves a negative remainder to restore
        if (!s_q.dr[0])
        begin
          alu_if.a = s_q.br;
          alu_if.sub = s_q.b[15];
          alu_if.cin = s_q.b[15];
          s_d.br = alu_if.sum;
        end
        s_d.st = ST_FIN;
      end

      ST_SSTEP:
      begin
        if (s_q.left)
        begin
          alu_if.a = s_q.br;
          alu_if.cin = (s_q.op == OP_ARITH_SHIFT_COMBINED_OP) && s_q.dr[15];
          s_d.br = alu_if.sum;
          s_d.b = alu_if.sum;
          s_d.dr = {s_q.dr[14:0], 1'b0};
          s_d.c = s_q.br[15];
          s_d.v = s_q.v || (alu_if.sum[15] != s_q.br[15]);
        end
        else
        begin
          s_d.br = {s_q.br[15], s_q.br[15:1]};
          if (s_q.op == OP_ARITH_SHIFT_COMBINED_OP)
            s_d.dr = {s_q.br[0], s_q.dr[15:1]};
          s_d.c = (s_q.op == OP_ARITH_SHIFT_COMBINED_OP) ? s_q.dr[0] : s_q.br[0];
        end
        s_d.cnt = s_q.cnt - 6'h01;
        if (s_q.cnt == 6'h01)
          s_d.st = ST_FIN;
      end

      ST_FIN:
      begin
        s_d.reshi = s_q.br;
        s_d.reslo = s_q.dr;
        case (s_q.op)
          OP_MUL:
            cc = {s_q.br[15], {s_q.br, s_q.dr} == 32'h0000_0000, 1'b0,
                  s_q.br != {16{s_q.dr[15]}}};
          OP_DIV:
          begin
            if (s_q.v)
            begin
              cc = {1'b0, s_q.c, 1'b1, s_q.c};
              s_d.reshi = s_q.reshi;
              s_d.reslo = s_q.reslo;
            end
            else
            begin
              cc = {quo[15], quo == 16'h0000, qerr, 1'b0};
              s_d.reshi = qerr ? s_q.reshi : quo;
              s_d.reslo = qerr ? s_q.reslo : rem;
            end
          end
          OP_ASH:
            cc = {s_q.br[15], s_q.br == 16'h0000, s_q.v, s_q.c};
          default:
            cc = {s_q.br[15], {s_q.br, s_q.dr} == 32'h0000_0000, s_q.v, s_q.c};
        endcase
        s_d.cc_out = cc;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.op_done = 1'b1;
        s_d.st = ST_IDLE;
      end

      default:
        s_d.st = start ? ST_LOAD : ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= MDS_RST;
    else
      s_q <= s_d;
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign busy    = s_q.busy;
  assign op_done = s_q.op_done;
  assign cc_out  = s_q.cc_out;

  a_mul_start_clear:
    assert property (@(posedge pclk) disable iff (!presetn)
      (start && pwdata[2:1] == OP_MUL) |=> (!s_q.ext && s_q.cnt == MUL_STEPS))
    else $error("multiply start did not clear carry and load count");

  a_mul_special:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == ST_LOAD && s_q.op == OP_MUL && s_q.dr == MOST_NEG && s_q.b == MOST_NEG)
      |=> (s_q.st == ST_FIN && s_q.br == MUL_SPECIAL_HI && s_q.dr == 16'h0000))
    else $error("special product not generated directly");

  a_mul_select:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == ST_MSTEP) |-> (alu_if.pass == (s_q.dr[0] == s_q.ext))
                             && (alu_if.sub == (s_q.dr[0] && !s_q.ext)))
    else $error("multiply step chose the wrong operation");

  a_mul_shift_in:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == ST_MSTEP) |=> (s_q.ext == $past(s_q.dr[0]))
                             && (s_q.dr[15] == $past(alu_if.sum[0])))
    else $error("multiply shift lost a bit");

  a_mul_length:
    assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_q.st == ST_MSTEP) |-> (s_q.cnt == MUL_STEPS)
      ##15 (s_q.st == ST_MSTEP && s_q.cnt == 6'h01) ##1 (s_q.st == ST_FIN))
    else $error("multiply loop did not run sixteen steps");

  a_carry_in:
    assert property (@(posedge pclk) disable iff (!presetn)
      (alu_if.sub && !alu_if.pass) |-> alu_if.cin)
    else $error("subtraction without carry-in");

  a_div_select:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == ST_DSTEP) |-> (alu_if.sub == (s_q.dr[0] ^ s_q.b[15]))
      ##1 (s_q.dr[0] == !$past(alu_if.sum[15])))
    else $error("divide pass chose the wrong operation");

  a_div_overflow:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == ST_DFIRST && (qbit || s_q.br[15])) |=> (s_q.st == ST_FIN && s_q.v))
    else $error("quotient overflow did not abort");

  a_zero_divisor:
    assert property (@(posedge pclk) disable iff (!presetn)
      (start && pwdata[2:1] == OP_DIV && s_q.dst == 16'h0000)
      |-> ##3 (s_q.cc_out[2:0] == 3'h7 && s_q.op_done))
    else $error("zero divisor did not set Z, V and C");

  a_done_pulse:
    assert property (@(posedge pclk) disable iff (!presetn)
      s_q.op_done |-> (!s_q.busy ##1 !s_q.op_done))
    else $error("done pulse too long or busy still set");

endmodule

// file: mds_pkg.sv
package mds_pkg;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_SRC   = 8'h04;
  localparam logic [7:0] ADDR_SRCLO = 8'h08;
  localparam logic [7:0] ADDR_DST   = 8'h0C;
  localparam logic [7:0] ADDR_RESHI = 8'h10;
  localparam logic [7:0] ADDR_RESLO = 8'h14;
  localparam logic [7:0] ADDR_STAT  = 8'h18;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CC_C           = 0;
  localparam int CC_V           = 1;
  localparam int CC_Z           = 2;
  localparam int CC_N           = 3;

  // Arithmetic constants and step counts
  localparam logic [15:0] MOST_NEG       = 16'h8000;
  localparam logic [15:0] MUL_SPECIAL_HI = 16'h4000;
  localparam logic [5:0]  MUL_STEPS      = 6'h10;
  localparam logic [5:0]  DIV_STEPS      = 6'h0F;

  typedef enum logic [1:0] {
    OP_MUL  = 2'h0,
    OP_DIV  = 2'h1,
    OP_ASH  = 2'h2,
    OP_ARITH_SHIFT_COMBINED_OP = 2'h3
  } mds_op_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_LOAD   = 3'h1,
    ST_MSTEP  = 3'h3,
    ST_DFIRST = 3'h2,
    ST_DSTEP  = 3'h6,
    ST_DFIX   = 3'h7,
    ST_SSTEP  = 3'h5,
    ST_FIN    = 3'h4
  } mds_st_t;

  typedef struct packed {
    mds_st_t     st;
    mds_op_t     op;
    logic [15:0] br;
    logic [15:0] dr;
    logic [15:0] b;
    logic        ext;
    logic [5:0]  cnt;
    logic        left;
    logic        negd;
    logic        v;
    logic        c;
    logic [15:0] src;
    logic [15:0] srclo;
    logic [15:0] dst;
    logic [15:0] reshi;
    logic [15:0] reslo;
    logic        busy;
    logic        done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        op_done;
    logic [3:0]  cc_out;
  } mds_state_t;

  localparam mds_state_t MDS_RST = '0;

endpackage

// file: mds_alu_if.sv
`timescale 1ns/1ps
interface mds_alu_if;
  logic [15:0] a;
  logic [15:0] b;
  logic        sub;
  logic        pass;
  logic        cin;
  logic [15:0] sum;
  logic        ovf;

  modport seq (output a, b, sub, pass, cin, input sum, ovf);
  modport alu (input a, b, sub, pass, cin, output sum, ovf);
endinterface

// file: mds_alu.sv
`timescale 1ns/1ps
module mds_alu
  import mds_pkg::*;
(
  // Operand and result lines
  mds_alu_if.alu bus
);

  logic [15:0] bb;

  // Subtraction is A plus inverted B with the carry-in supplying the one
  always_comb
  begin
    bb = bus.pass ? 16'h0000 : (bus.sub ? ~bus.b : bus.b);
    bus.sum = bus.a + bb + {15'h0000, bus.cin};
    bus.ovf = (bus.a[15] == bb[15]) && (bus.sum[15] != bus.a[15]);
  end

endmodule

// file: mds_host.sv
`timescale 1ns/1ps
module mds_host
(
  // Clock
  input  wire logic        pclk,
  // APB master side
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  bit hung;

  initial
  begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    hung    = 1'b0;
  end

  // Request held until pready is seen high or 16 cycles pass; paddr and pwdata then show inverted values
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    paddr  <= a;
    pwrite <= wr;
    pwdata <= wd;
    pstrb  <= st;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    hung = hung | (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top
  import mds_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        op_done;
  logic [3:0]  cc_out;
  int          fails;
  int          samples_checked;
  logic [15:0] last_hi;
  logic [15:0] last_lo;

  localparam logic [49:0] CORNER [23] = '{
    {OP_MUL, 16'h8000, 16'h0, 16'h8000}, {OP_MUL, 16'h8000, 16'h0, 16'h0003},
    {OP_MUL, 16'h0005, 16'h0, 16'h8000}, {OP_MUL, 16'h8000, 16'h0, 16'hFFFF},
    {OP_MUL, 16'h7FFF, 16'h0, 16'h7FFF}, {OP_MUL, 16'hFFFF, 16'h0, 16'hFFFF},
    {OP_MUL, 16'h0000, 16'h0, 16'h1234}, {OP_DIV, 16'h0001, 16'h0, 16'h0000},
    {OP_DIV, 16'h8000, 16'h0, 16'h0003}, {OP_DIV, 16'h0000, 16'h0011, 16'h0005},
    {OP_DIV, 16'hFFFF, 16'hFFEF, 16'h0005}, {OP_DIV, 16'h0000, 16'h0011, 16'hFFFB},
    {OP_DIV, 16'hFFFF, 16'hFFEF, 16'hFFFB}, {OP_DIV, 16'h4000, 16'h0000, 16'h0002},
    {OP_DIV, 16'h0000, 16'h7FFF, 16'h0001}, {OP_DIV, 16'h0000, 16'h8000, 16'h0001},
    {OP_DIV, 16'hFFFF, 16'h8000, 16'h0001}, {OP_DIV, 16'hFFFF, 16'h8000, 16'hFFFF},
    {OP_ASH, 16'h8001, 16'h0, 16'h0001}, {OP_ASH, 16'h8000, 16'h0, 16'h003F},
    {OP_ASH, 16'h1234, 16'h0, 16'h0000}, {OP_ARITH_SHIFT_COMBINED_OP, 16'h8000, 16'h0001, 16'h0020},
    {OP_ARITH_SHIFT_COMBINED_OP, 16'h4001, 16'h8001, 16'h001F}
  };
  localparam logic [7:0] REGS [7] = '{ADDR_CTRL, ADDR_SRC, ADDR_SRCLO, ADDR_DST,
                                      ADDR_RESHI, ADDR_RESLO, ADDR_STAT};

  mds_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .op_done(op_done), .cc_out(cc_out));
  mds_host host_u (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic wrap_up();
    if (host_u.hung)
      fails++;
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hF);
    logic [31:0] rd;
    logic        e;
    host_u.xfer(a, 1'b1, d, st, rd, e);
    if (host_u.hung)
      wrap_up();
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic eexp = 1'b0);
    logic [31:0] rd;
    logic        e;
    host_u.xfer(a, 1'b0, 32'h0, 4'h0, rd, e);
    if (host_u.hung)
      wrap_up();
    check(what, exp, rd);
    check({what, " slverr"}, {31'h0, eexp}, {31'h0, e});
  endtask

  // Divide errors leave the result registers as the previous operation left them
  task automatic predict(input mds_op_t op, input logic [15:0] s, sl, d,
                         output logic [15:0] eh, el, output logic [3:0] cc,
                         output int lat, output bit cv_ok);
    logic signed [31:0] p;
    longint             dd, dv, q, r;
    logic [31:0]        x;
    int                 n, w;
    logic               c, v, o;
    eh = last_hi;
    el = last_lo;
    cv_ok = 1'b1;
    c = 1'b0;
    v = 1'b0;
    if (op == OP_MUL)
    begin
      p = $signed(s) * $signed(d);
      {eh, el} = p;
      cc = {p[31], p == 32'h0, 1'b0, p[31:15] != {17{p[31]}}};
      lat = (s == MOST_NEG && d == MOST_NEG) ? 2 : 18;
    end
    else if (op == OP_DIV)
    begin
      dd = $signed({s, sl});
      dv = $signed(d);
      lat = 2;
      cc = 4'h2;
      if (d == 16'h0)
        cc = 4'h7;
      else if ({s, sl} != 32'h8000_0000)
      begin
        q = dd / dv;
        r = dd % dv;
        lat = 3;
        if (q < 32768 && q > -32768)
        begin
          eh = q[15:0];
          el = r[15:0];
          cc = {eh[15], eh == 16'h0, 2'b00};
          lat = 19;
        end
      end
    end
    else
    begin
      w = (op == OP_ARITH_SHIFT_COMBINED_OP) ? 32 : 16;
      x = (op == OP_ARITH_SHIFT_COMBINED_OP) ? {s, sl} : {16'h0, s};
      n = $signed(d[5:0]);
      lat = 2 + (n < 0 ? -n : n);
      cv_ok = (n != 0);
      for (int i = 0; i < (n < 0 ? -n : n); i++)
        if (n > 0)
        begin
          o = x[w-1];
          c = o;
          x = x << 1;
          v = v | (x[w-1] != o);
        end
        else
        begin
          c = x[0];
          x = (x >> 1) | ({31'h0, x[w-1]} << (w - 1));
        end
      eh = (op == OP_ARITH_SHIFT_COMBINED_OP) ? x[31:16] : x[15:0];
      el = (op == OP_ARITH_SHIFT_COMBINED_OP) ? x[15:0] : 16'hxxxx;
      cc = {eh[15], (op == OP_ARITH_SHIFT_COMBINED_OP) ? x == 32'h0 : x[15:0] == 16'h0, v, c};
    end
  endtask

  task automatic wait_done(input int lat);
    int k;
    k = 0;
    do
    begin
      @(posedge pclk);
      #1;
      k++;
      if (k == 1)
        check("busy after start", 32'h1, busy);
    end
    while (op_done !== 1'b1 && k < 100);
    check("latency", lat, k);
    if (op_done !== 1'b1)
      wrap_up();
    check("busy at done", 32'h0, busy);
  endtask

  task automatic run_op(input mds_op_t op, input logic [15:0] s, sl, d);
    logic [15:0] eh, el;
    logic [3:0]  cc;
    logic [3:0]  m;
    int          lat;
    bit          cv_ok;
    predict(op, s, sl, d, eh, el, cc, lat, cv_ok);
    wr(ADDR_SRC, {16'h0, s});
    wr(ADDR_SRCLO, {16'h0, sl});
    wr(ADDR_DST, {16'h0, d});
    wr(ADDR_CTRL, {29'h0, op, 1'b1});
    wait_done(lat);
    m = cv_ok ? 4'hF : 4'hC;
    check("cc port", cc & m, cc_out & m);
    rd_chk("result hi", ADDR_RESHI, {16'h0, eh});
    if (!$isunknown(el))
      rd_chk("result lo", ADDR_RESLO, {16'h0, el});
    if (cv_ok)
      rd_chk("status", ADDR_STAT, {28'h1, cc});
    last_hi = eh;
    last_lo = el;
  endtask

  initial
  begin
    mds_op_t     op;
    logic [31:0] v32;
    presetn = 1'b0;
    fails = 0;
    samples_checked = 0;
    last_hi = 16'h0;
    last_lo = 16'h0;
    void'($urandom(44676));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (REGS[i])
      rd_chk("reset value", REGS[i], 32'h0);
    rd_chk("unmapped", 8'h1C, 32'h0, 1'b1);
    wr(ADDR_RESHI, 32'h0000_1234);
    rd_chk("read only", ADDR_RESHI, 32'h0);
    wr(ADDR_SRC, 32'hFFFF_ABCD);
    rd_chk("upper half", ADDR_SRC, 32'h0000_ABCD);
    wr(ADDR_DST, 32'h0000_1234, 4'h2);
    rd_chk("byte strobe", ADDR_DST, 32'h0000_1200);
    foreach (CORNER[i])
      run_op(mds_op_t'(CORNER[i][49:48]), CORNER[i][47:32], CORNER[i][31:16],
             CORNER[i][15:0]);
    repeat (30)
    begin
      op = mds_op_t'($urandom_range(3, 0));
      v32 = $urandom;
      v32 = $signed(v32) >>> $urandom_range(31, 0);
      run_op(op, v32[31:16], v32[15:0], 16'($urandom));
    end
    // A second start during a multiply must not disturb it
    wr(ADDR_SRC, 32'h0003);
    wr(ADDR_DST, 32'h0005);
    wr(ADDR_CTRL, {29'h0, OP_MUL, 1'b1});
    wr(ADDR_DST, 32'h0007);
    wr(ADDR_CTRL, {29'h0, OP_DIV, 1'b1});
    wait_done(18 - 6);
    rd_chk("busy start lo", ADDR_RESLO, 32'h0000_000F);
    wr(ADDR_CTRL, {29'h0, OP_DIV, 1'b1}, 4'hE);
    repeat (25)
    begin
      @(posedge pclk);
      #1;
      check("stray start", 32'h0, {busy, op_done});
    end
    rd_chk("last op", ADDR_CTRL, 32'h0);
    wrap_up();
  end
endmodule
